/* File: src/uswf_top.sv */
// Purpose: Software flow control, FIFO levels and enhanced register gating
// Assumes: Receiver, transmitter and FIFOs run on ref_clk; mode pins async
// Notes:   APB slave, one wait-free access phase, pslverr on unmapped address
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/100ps

module uswf_top (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Receiver side
	input  wire logic        rx_char_valid,
	input  wire logic [7:0]  rx_char,
	output logic             rx_store,
	output logic [7:0]       rx_store_char,
	output logic             tx_halt,
	// Transmitter and FIFO side
	input  wire logic [7:0]  tx_level_in,
	input  wire logic [7:0]  rx_level_in,
	input  wire logic        tx_load,
	input  wire logic        tx_busy,
	input  wire logic        send_stop_req,
	input  wire logic        send_start_req,
	input  wire logic        flow_char_ack,
	output logic             flow_char_valid,
	output logic [7:0]       flow_char,
	output logic             tx_trig_int,
	output logic             rx_trig_int,
	// Line status and modem inputs
	input  wire logic [7:0]  line_state_in,
	input  wire logic [3:0]  mode_pins,
	// Pin drivers
	input  wire logic        tx_bit,
	input  wire logic        ir_bit,
	input  wire logic [2:0]  cfg_mem_in,
	output logic             serial_out,
	output logic             infrared_serial_out,
	output logic             rts_n,
	output logic             dtr_n,
	output logic             cfg_mem_clock,
	output logic             cfg_mem_select,
	output logic             cfg_mem_data_out
);
	typedef enum logic [1:0] {FL_IDLE, FL_FIRST, FL_SECOND} uswf_state_t;

	logic [7:0] enhanced_feature_ctrl, feature_ctrl_reg, scratch_byte;
	logic [7:0] interrupt_enable_reg, fifo_ctrl_reg, modem_ctrl_reg;
	logic [7:0] mode_select_status_reg, line_ctrl_reg, line_state_reg;
	logic [7:0] div_low, divisor_high_byte, divisor_fraction;
	logic [7:0] tx_fifo_level, rx_fifo_level, tx_trigger_level, rx_trigger_level;
	logic [7:0] stop_char_first, stop_char_second;
	logic [7:0] start_char_first, start_char_second;
	logic [3:0] flow_char_status, next_flow_char_status;
	logic [1:0] isr_enh;
	logic [3:0] mode_meta, mode_sync;
	logic       wr_acc, rd_acc, enh_en, rs485_en, dir_tx;
	logic       prev_start1, prev_stop1, kind_stop, flow_sent;
	logic       rx_start_ev, rx_stop_ev, flow_hit, special_ev, store_ok;
	logic [1:0] rx_sel, tx_sel;
	logic [7:0] rd_val;
	logic       rd_hit;
	uswf_state_t fl_state;

	assign enh_en   = enhanced_feature_ctrl[uswf_pkg::EFR_ENH];
	assign rs485_en = feature_ctrl_reg[uswf_pkg::FEATURE_CTRL_REG_RS485];
	assign rx_sel   = enhanced_feature_ctrl[1:0];
	assign tx_sel   = enhanced_feature_ctrl[3:2];
	assign wr_acc   = psel & penable & pready & pwrite;
	assign rd_acc   = psel & penable & pready & ~pwrite;

	// --------------------------------------------------------------
	// Synchroniser for the mode pins
	// --------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_meta <= 4'h0;
			mode_sync <= 4'h0;
		end else begin
			mode_meta <= mode_pins;
			mode_sync <= mode_meta;
		end
	end

	// --------------------------------------------------------------
	// APB read mux
	// --------------------------------------------------------------
	// Read value and address hit
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 8'h00;
		if (paddr == uswf_pkg::OFS_DIV_LOW) rd_val = div_low;
		else if (paddr == uswf_pkg::OFS_IER) rd_val = interrupt_enable_reg;
		else if (paddr == uswf_pkg::OFS_ISR)
			rd_val = {2'b00, isr_enh, 3'b000, ~(|isr_enh | tx_trig_int | rx_trig_int)};
		else if (paddr == uswf_pkg::OFS_LCR) rd_val = line_ctrl_reg;
		else if (paddr == uswf_pkg::OFS_MCR) rd_val = modem_ctrl_reg;
		else if (paddr == uswf_pkg::OFS_LSR) rd_val = line_state_reg;
		else if (paddr == uswf_pkg::OFS_MSR)
			rd_val = {mode_sync, mode_select_status_reg[3:0]};
		else if (paddr == uswf_pkg::OFS_SPR) rd_val = scratch_byte;
		else if (paddr == uswf_pkg::OFS_FEATURE_CTRL_REG) rd_val = feature_ctrl_reg;
		else if (paddr == uswf_pkg::OFS_EFR) rd_val = enhanced_feature_ctrl;
		else if (paddr == uswf_pkg::OFS_TX_FIFO_LEVEL) rd_val = tx_fifo_level;
		else if (paddr == uswf_pkg::OFS_RX_FIFO_LEVEL) rd_val = rx_fifo_level;
		else if (paddr == uswf_pkg::OFS_XSTAT) rd_val = {4'h0, flow_char_status};
		else if (paddr == uswf_pkg::OFS_DIV_HIGH) rd_val = divisor_high_byte;
		else if (paddr == uswf_pkg::OFS_DIV_FRAC) rd_val = divisor_fraction;
		else if (paddr == uswf_pkg::OFS_FCR || paddr == uswf_pkg::OFS_TX_TRIGGER_LEVEL ||
			paddr == uswf_pkg::OFS_RX_TRIGGER_LEVEL || paddr == uswf_pkg::OFS_STOP1 ||
			paddr == uswf_pkg::OFS_STOP2 || paddr == uswf_pkg::OFS_START1 ||
			paddr == uswf_pkg::OFS_START2) rd_val = 8'h00;
		else rd_hit = 1'b0;
	end

	// Answer in the first access cycle; data sampled at the setup edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~rd_hit;
			if (psel & ~penable & ~pwrite)
				prdata <= {24'h00_0000, rd_val};
		end
	end

	// --------------------------------------------------------------
	// Plain and gated configuration registers
	// --------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_low                <= uswf_pkg::RST_DIV_LOW;
			divisor_high_byte      <= uswf_pkg::RST_ZERO;
			divisor_fraction       <= uswf_pkg::RST_ZERO;
			line_ctrl_reg          <= uswf_pkg::RST_ZERO;
			scratch_byte           <= uswf_pkg::RST_SPR;
			feature_ctrl_reg       <= uswf_pkg::RST_ZERO;
			enhanced_feature_ctrl  <= uswf_pkg::RST_ZERO;
			interrupt_enable_reg   <= uswf_pkg::RST_ZERO;
			fifo_ctrl_reg          <= uswf_pkg::RST_ZERO;
			modem_ctrl_reg         <= uswf_pkg::RST_ZERO;
			mode_select_status_reg <= uswf_pkg::RST_ZERO;
			tx_trigger_level       <= uswf_pkg::RST_ZERO;
			rx_trigger_level       <= uswf_pkg::RST_ZERO;
			stop_char_first        <= uswf_pkg::RST_ZERO;
			stop_char_second       <= uswf_pkg::RST_ZERO;
			start_char_first       <= uswf_pkg::RST_ZERO;
			start_char_second      <= uswf_pkg::RST_ZERO;
		end else if (wr_acc) begin
			if (paddr == uswf_pkg::OFS_DIV_LOW) div_low <= pwdata[7:0];
			else if (paddr == uswf_pkg::OFS_DIV_HIGH) divisor_high_byte <= pwdata[7:0];
			else if (paddr == uswf_pkg::OFS_DIV_FRAC) divisor_fraction <= pwdata[7:0];
			else if (paddr == uswf_pkg::OFS_LCR) line_ctrl_reg <= pwdata[7:0];
			else if (paddr == uswf_pkg::OFS_SPR) scratch_byte <= pwdata[7:0];
			else if (paddr == uswf_pkg::OFS_FEATURE_CTRL_REG) feature_ctrl_reg <= pwdata[7:0];
			else if (paddr == uswf_pkg::OFS_EFR) enhanced_feature_ctrl <= pwdata[7:0];
			else if (paddr == uswf_pkg::OFS_IER)
				interrupt_enable_reg <= enh_en ? pwdata[7:0] :
					(interrupt_enable_reg & uswf_pkg::ENH_IER) | (pwdata[7:0] & ~uswf_pkg::ENH_IER);
			else if (paddr == uswf_pkg::OFS_FCR)
				fifo_ctrl_reg <= enh_en ? pwdata[7:0] :
					(fifo_ctrl_reg & uswf_pkg::ENH_FCR) | (pwdata[7:0] & ~uswf_pkg::ENH_FCR);
			else if (paddr == uswf_pkg::OFS_MCR)
				modem_ctrl_reg <= enh_en ? pwdata[7:0] :
					(modem_ctrl_reg & uswf_pkg::ENH_MCR) | (pwdata[7:0] & ~uswf_pkg::ENH_MCR);
			else if (paddr == uswf_pkg::OFS_MSR && enh_en)
				mode_select_status_reg <= pwdata[7:0] & uswf_pkg::ENH_MSR;
			else if (paddr == uswf_pkg::OFS_TX_TRIGGER_LEVEL) tx_trigger_level <= pwdata[7:0];
			else if (paddr == uswf_pkg::OFS_RX_TRIGGER_LEVEL) rx_trigger_level <= pwdata[7:0];
			else if (paddr == uswf_pkg::OFS_STOP1) stop_char_first <= pwdata[7:0];
			else if (paddr == uswf_pkg::OFS_STOP2) stop_char_second <= pwdata[7:0];
			else if (paddr == uswf_pkg::OFS_START1) start_char_first <= pwdata[7:0];
			else if (paddr == uswf_pkg::OFS_START2) start_char_second <= pwdata[7:0];
		end
	end

	// --------------------------------------------------------------
	// Receive compare
	// --------------------------------------------------------------
	// Match decode per receive selection
	always_comb begin
		rx_start_ev = 1'b0;
		rx_stop_ev  = 1'b0;
		case (rx_sel)
			2'b10: begin
				rx_start_ev = rx_char == start_char_first;
				rx_stop_ev  = rx_char == stop_char_first;
			end
			2'b01: begin
				rx_start_ev = rx_char == start_char_second;
				rx_stop_ev  = rx_char == stop_char_second;
			end
			2'b11: begin
				if (tx_sel == 2'b10 || tx_sel == 2'b01) begin
					rx_start_ev = rx_char == start_char_first || rx_char == start_char_second;
					rx_stop_ev  = rx_char == stop_char_first || rx_char == stop_char_second;
				end else begin
					rx_start_ev = prev_start1 && rx_char == start_char_second;
					rx_stop_ev  = prev_stop1 && rx_char == stop_char_second;
				end
			end
			default: ;
		endcase
		rx_start_ev = rx_char_valid & rx_start_ev;
		rx_stop_ev  = rx_char_valid & rx_stop_ev;
		flow_hit    = rx_start_ev | rx_stop_ev;
		special_ev  = rx_char_valid & enhanced_feature_ctrl[uswf_pkg::EFR_SPECIAL] &
			(rx_char == stop_char_second);
		store_ok    = ~flow_hit | (special_ev & rx_sel != 2'b01);
	end

	// Pair tracking, FIFO store and halt state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prev_start1   <= 1'b0;
			prev_stop1    <= 1'b0;
			rx_store      <= 1'b0;
			rx_store_char <= 8'h00;
			tx_halt       <= 1'b0;
		end else begin
			rx_store <= rx_char_valid & store_ok;
			if (rx_char_valid) begin
				prev_start1   <= rx_char == start_char_first;
				prev_stop1    <= rx_char == stop_char_first;
				rx_store_char <= rx_char;
			end
			if (rx_sel == 2'b00) tx_halt <= 1'b0;
			else if (rx_stop_ev) tx_halt <= 1'b1;
			else if (rx_start_ev | (rx_char_valid & modem_ctrl_reg[uswf_pkg::MCR_ANY])) tx_halt <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Transmit flow character sequencer
	// --------------------------------------------------------------
	assign flow_sent = flow_char_ack & flow_char_valid &
		(fl_state == FL_SECOND || (fl_state == FL_FIRST && tx_sel != 2'b11));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fl_state        <= FL_IDLE;
			flow_char_valid <= 1'b0;
			flow_char       <= 8'h00;
			kind_stop       <= 1'b0;
		end else begin
			case (fl_state)
				FL_IDLE: begin
					if (tx_sel != 2'b00 && (send_stop_req | send_start_req)) begin
						kind_stop       <= send_stop_req;
						flow_char_valid <= 1'b1;
						fl_state        <= tx_sel[1] ? FL_FIRST : FL_SECOND;
						if (tx_sel[1]) flow_char <= send_stop_req ? stop_char_first : start_char_first;
						else flow_char <= send_stop_req ? stop_char_second : start_char_second;
					end
				end
				FL_FIRST: begin
					if (tx_sel == 2'b00) begin
						fl_state        <= FL_IDLE;
						flow_char_valid <= 1'b0;
					end else if (flow_char_ack && tx_sel == 2'b11) begin
						fl_state  <= FL_SECOND;
						flow_char <= kind_stop ? stop_char_second : start_char_second;
					end else if (flow_char_ack) begin
						fl_state        <= FL_IDLE;
						flow_char_valid <= 1'b0;
					end
				end
				default: begin
					if (flow_char_ack || tx_sel == 2'b00) begin
						fl_state        <= FL_IDLE;
						flow_char_valid <= 1'b0;
					end
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// Flow character status and interrupt flags
	// --------------------------------------------------------------
	// Read clears only the bits that the read returned
	always_comb begin
		next_flow_char_status = flow_char_status;
		if (rd_acc && paddr == uswf_pkg::OFS_XSTAT)
			next_flow_char_status = flow_char_status & ~prdata[3:0];
		if (flow_sent) next_flow_char_status[3:2] = kind_stop ? 2'b01 : 2'b10;
		if (rx_start_ev | (rx_char_valid & tx_halt & modem_ctrl_reg[uswf_pkg::MCR_ANY] & ~rx_stop_ev))
			next_flow_char_status[1:0] = 2'b10;
		if (rx_stop_ev) next_flow_char_status[1:0] = 2'b01;
		if (enhanced_feature_ctrl[3:0] == 4'h0) next_flow_char_status = 4'h0;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flow_char_status <= 4'h0;
			isr_enh          <= 2'b00;
		end else begin
			flow_char_status <= next_flow_char_status;
			if (wr_acc && paddr == uswf_pkg::OFS_ISR && enh_en) isr_enh <= pwdata[5:4];
			if (special_ev) isr_enh[0] <= 1'b1;
			if (special_ev & rx_stop_ev) isr_enh[1] <= 1'b1;
		end
	end

	// --------------------------------------------------------------
	// Levels, triggers, direction and pins
	// --------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_fifo_level  <= 8'h00;
			rx_fifo_level  <= 8'h00;
			line_state_reg <= uswf_pkg::RST_LSR;
			tx_trig_int    <= 1'b0;
			rx_trig_int    <= 1'b0;
		end else begin
			tx_fifo_level  <= tx_level_in;
			rx_fifo_level  <= rx_level_in;
			line_state_reg <= line_state_in;
			tx_trig_int    <= tx_trigger_level != 8'h00 && tx_fifo_level < tx_trigger_level;
			rx_trig_int    <= rx_trigger_level != 8'h00 && rx_fifo_level >= rx_trigger_level;
		end
	end

	// Direction follows data only, never flow characters
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) dir_tx <= 1'b0;
		else if (!rs485_en) dir_tx <= 1'b0;
		else if (tx_load) dir_tx <= 1'b1;
		else if (!tx_busy && tx_level_in == 8'h00) dir_tx <= 1'b0;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			serial_out          <= 1'b1;
			infrared_serial_out <= 1'b0;
			rts_n               <= 1'b1;
			dtr_n               <= 1'b1;
			cfg_mem_clock       <= 1'b0;
			cfg_mem_select      <= 1'b0;
			cfg_mem_data_out    <= 1'b0;
		end else begin
			serial_out          <= tx_bit;
			infrared_serial_out <= ir_bit;
			rts_n               <= rs485_en ? dir_tx : ~modem_ctrl_reg[uswf_pkg::MCR_RTS];
			dtr_n               <= ~modem_ctrl_reg[uswf_pkg::MCR_DTR];
			cfg_mem_clock       <= cfg_mem_in[0];
			cfg_mem_select      <= cfg_mem_in[1];
			cfg_mem_data_out    <= cfg_mem_in[2];
		end
	end

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	a_status_forced: assert property (@(posedge ref_clk) disable iff (rst)
		enhanced_feature_ctrl[3:0] == 4'h0 |=> flow_char_status == 4'h0)
		else $error("flow status not zero with flow off");
	a_special_flag: assert property (@(posedge ref_clk) disable iff (rst)
		special_ev && rx_sel != 2'b01 |=> isr_enh[0] && rx_store)
		else $error("special char not flagged or stored");
	a_second_pair: assert property (@(posedge ref_clk) disable iff (rst)
		special_ev && rx_sel == 2'b01 |=> !rx_store && isr_enh == 2'b11)
		else $error("second stop handled wrongly");
	a_enh_frozen: assert property (@(posedge ref_clk) disable iff (rst)
		wr_acc && paddr == uswf_pkg::OFS_IER && !enh_en
		|=> interrupt_enable_reg[7:5] == $past(interrupt_enable_reg[7:5]))
		else $error("enhanced bits changed while locked");
	a_pair_order: assert property (@(posedge ref_clk) disable iff (rst)
		fl_state == FL_FIRST && flow_char_ack && tx_sel == 2'b11
		|=> fl_state == FL_SECOND && flow_char_valid)
		else $error("second flow char not sent");
	a_tx_trigger: assert property (@(posedge ref_clk) disable iff (rst)
		tx_trigger_level != 8'h00 && tx_fifo_level < tx_trigger_level |=> tx_trig_int)
		else $error("tx trigger missed");
	a_rx_trigger: assert property (@(posedge ref_clk) disable iff (rst)
		rx_trigger_level == 8'h00 |=> !rx_trig_int)
		else $error("rx trigger on invalid zero");
	a_dir_hold: assert property (@(posedge ref_clk) disable iff (rst)
		!dir_tx && !tx_load && flow_char_valid |=> !dir_tx)
		else $error("direction turned by flow char");
	a_sent_flag: assert property (@(posedge ref_clk) disable iff (rst)
		flow_sent && enhanced_feature_ctrl[3:0] != 4'h0 && $stable(enhanced_feature_ctrl)
		|=> flow_char_status[3] == !$past(kind_stop))
		else $error("sent kind not recorded");
	a_pready_next: assert property (@(posedge ref_clk) disable iff (rst)
		psel && !penable |=> pready ##1 !pready)
		else $error("apb answer timing wrong");
endmodule : uswf_top

/* File: src/uswf_pkg.sv */
// Purpose: Constants for the flow-control and FIFO-level register block
// Assumes: APB byte addresses, one 32-bit word per 8-bit register
// Notes:   Write-only registers read back as zero

package uswf_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_DIV_LOW  = 8'h00;
	localparam logic [7:0] OFS_IER      = 8'h04;
	localparam logic [7:0] OFS_ISR      = 8'h08;
	localparam logic [7:0] OFS_FCR      = 8'h0c;
	localparam logic [7:0] OFS_LCR      = 8'h10;
	localparam logic [7:0] OFS_MCR      = 8'h14;
	localparam logic [7:0] OFS_LSR      = 8'h18;
	localparam logic [7:0] OFS_MSR      = 8'h1c;
	localparam logic [7:0] OFS_SPR      = 8'h20;
	localparam logic [7:0] OFS_FEATURE_CTRL_REG     = 8'h24;
	localparam logic [7:0] OFS_EFR      = 8'h28;
	localparam logic [7:0] OFS_TX_FIFO_LEVEL    = 8'h2c;
	localparam logic [7:0] OFS_TX_TRIGGER_LEVEL    = 8'h30;
	localparam logic [7:0] OFS_RX_FIFO_LEVEL    = 8'h34;
	localparam logic [7:0] OFS_RX_TRIGGER_LEVEL    = 8'h38;
	localparam logic [7:0] OFS_STOP1    = 8'h3c;
	localparam logic [7:0] OFS_STOP2    = 8'h40;
	localparam logic [7:0] OFS_START1   = 8'h44;
	localparam logic [7:0] OFS_START2   = 8'h48;
	localparam logic [7:0] OFS_XSTAT    = 8'h4c;
	localparam logic [7:0] OFS_DIV_HIGH = 8'h50;
	localparam logic [7:0] OFS_DIV_FRAC = 8'h54;
	// ----------------------------------------------------------------
	// Reset values and write-gate masks
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_DIV_LOW  = 8'h01;
	localparam logic [7:0] RST_ISR      = 8'h01;
	localparam logic [7:0] RST_LSR      = 8'h60;
	localparam logic [7:0] RST_SPR      = 8'hff;
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam logic [7:0] ENH_IER      = 8'he0;
	localparam logic [7:0] ENH_FCR      = 8'h30;
	localparam logic [7:0] ENH_MCR      = 8'he0;
	localparam logic [7:0] ENH_MSR      = 8'hff;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int EFR_SPECIAL = 5;
	localparam int EFR_ENH     = 4;
	localparam int FEATURE_CTRL_REG_RS485  = 5;
	localparam int MCR_ANY     = 5;
	localparam int MCR_RTS     = 1;
	localparam int MCR_DTR     = 0;
endpackage : uswf_pkg

/* File: sim/uswf_remote.sv */
// Purpose: Remote serial device seen at the receive and flow ports
// Assumes: One received character per valid pulse
// Notes:   Offered flow characters are acked after dly+1 cycles
`timescale 1ns/100ps
module uswf_remote (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Flow characters to the line
	input  wire logic       flow_char_valid,
	input  wire logic [7:0] flow_char,
	output logic            flow_char_ack,
	// Characters from the line
	output logic            rx_char_valid,
	output logic [7:0]      rx_char
);
	logic [7:0] seen;
	int         cnt;
	int         dly = 2;
	int         taken;
	initial begin
		rx_char_valid = 1'b0;
		rx_char       = 8'h00;
	end
	// One character, then the line shows its inverse
	task send(input logic [7:0] c);
		@(posedge ref_clk);
		rx_char_valid <= 1'b1;
		rx_char       <= c;
		@(posedge ref_clk);
		rx_char_valid <= 1'b0;
		rx_char       <= ~c;
		#1;
	endtask : send
	// Slow ack, keeps last taken character
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flow_char_ack <= 1'b0;
			cnt           <= 0;
			taken         <= 0;
		end else begin
			if (flow_char_valid && flow_char_ack) begin
				seen  <= flow_char;
				taken <= taken + 1;
			end
			flow_char_ack <= flow_char_valid && !flow_char_ack && cnt >= dly;
			cnt           <= (flow_char_valid && !flow_char_ack) ? cnt + 1 : 0;
		end
	end
endmodule : uswf_remote

/* File: sim/uswf_top_tb.sv */
// Purpose: Self-checking bench for the flow-control register block
// Assumes: Wait-free APB slave
// Notes:   Remote model drives the receive side
`timescale 1ns/100ps
module uswf_top_tb;
	logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0]  paddr = 8'h00, tx_lvl = 8'h00, rx_lvl = 8'h00, rd, rsc, fch, rxc;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, rsv, halt, fvld, fack, rxv, txi, rxi, so, iro, rts_n, dtr_n, cc, cs, cd;
	logic        tx_bit = 1'b1, r_stop = 1'b0, r_start = 1'b0, tx_load = 1'b0, tx_busy = 1'b0, ir_bit = 1'b0;
	logic [7:0]  lsr_in = 8'h60;
	logic [3:0]  mode_in = 4'h0;
	logic [2:0]  cfg_in = 3'h0;
	int          failures = 0, cmp_count = 0;
	always #10 ref_clk = ~ref_clk;
	uswf_top uswf_top_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_char_valid(rxv),
		.rx_char(rxc), .rx_store(rsv), .rx_store_char(rsc), .tx_halt(halt), .tx_level_in(tx_lvl),
		.rx_level_in(rx_lvl), .tx_load(tx_load), .tx_busy(tx_busy), .send_stop_req(r_stop), .send_start_req(r_start),
		.flow_char_ack(fack), .flow_char_valid(fvld), .flow_char(fch), .tx_trig_int(txi), .rx_trig_int(rxi),
		.line_state_in(lsr_in), .mode_pins(mode_in), .tx_bit(tx_bit), .ir_bit(ir_bit), .cfg_mem_in(cfg_in),
		.serial_out(so), .infrared_serial_out(iro), .rts_n(rts_n), .dtr_n(dtr_n), .cfg_mem_clock(cc),
		.cfg_mem_select(cs), .cfg_mem_data_out(cd));
	uswf_remote uswf_remote_inst (.ref_clk(ref_clk), .rst(rst), .flow_char_valid(fvld), .flow_char(fch),
		.flow_char_ack(fack), .rx_char_valid(rxv), .rx_char(rxc));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd      = prdata[7:0];
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask : rdc
	task automatic t_reset;
		chk({so, rts_n, dtr_n, iro, cc, cs, cd}, 8'h70);
		rst <= 1'b0;
		rdc(uswf_pkg::OFS_DIV_LOW, 8'h01);
		rdc(uswf_pkg::OFS_ISR, 8'h01);
		rdc(uswf_pkg::OFS_LSR, 8'h60);
		rdc(uswf_pkg::OFS_SPR, 8'hff);
		rdc(uswf_pkg::OFS_EFR, 8'h00);
		rdc(uswf_pkg::OFS_MCR, 8'h00);
		rdc(uswf_pkg::OFS_XSTAT, 8'h00);
		tx_bit <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk({7'h0, so}, 8'h00);
	endtask : t_reset
	task automatic t_gate;
		apb(1'b1, uswf_pkg::OFS_IER, 8'hff);
		rdc(uswf_pkg::OFS_IER, 8'h1f);
		apb(1'b1, uswf_pkg::OFS_EFR, 8'h10);
		apb(1'b1, uswf_pkg::OFS_IER, 8'hff);
		apb(1'b1, uswf_pkg::OFS_EFR, 8'h00);
		apb(1'b1, uswf_pkg::OFS_IER, 8'h00);
		rdc(uswf_pkg::OFS_IER, 8'he0);
		apb(1'b0, 8'hfc, 8'h00);
		chk({err, rd[6:0]}, 8'h80);
	endtask : t_gate
	task automatic t_level;
		tx_lvl <= 8'hff;
		rx_lvl <= 8'hff;
		rdc(uswf_pkg::OFS_TX_FIFO_LEVEL, 8'hff);
		rdc(uswf_pkg::OFS_RX_FIFO_LEVEL, 8'hff);
		apb(1'b1, uswf_pkg::OFS_TX_TRIGGER_LEVEL, 8'h10);
		apb(1'b1, uswf_pkg::OFS_RX_TRIGGER_LEVEL, 8'h20);
		tx_lvl <= 8'h0f;
		rx_lvl <= 8'h20;
		repeat (3) @(posedge ref_clk);
		chk({txi, rxi}, 8'h03);
		tx_lvl <= 8'h10;
		rx_lvl <= 8'h1f;
		repeat (3) @(posedge ref_clk);
		chk({txi, rxi}, 8'h00);
	endtask : t_level
	task automatic t_rxflow;
		apb(1'b1, uswf_pkg::OFS_STOP1, 8'h13);
		apb(1'b1, uswf_pkg::OFS_START1, 8'h11);
		apb(1'b1, uswf_pkg::OFS_EFR, 8'h1a);
		uswf_remote_inst.send(8'h13);
		chk({rsv, halt}, 8'h01);
		rdc(uswf_pkg::OFS_XSTAT, 8'h01);
		rdc(uswf_pkg::OFS_XSTAT, 8'h00);
		uswf_remote_inst.send(8'h11);
		chk({rsv, halt}, 8'h00);
		rdc(uswf_pkg::OFS_XSTAT, 8'h02);
		uswf_remote_inst.send(8'h41);
		chk(rsc, 8'h41);
		apb(1'b1, uswf_pkg::OFS_STOP2, 8'h7e);
		apb(1'b1, uswf_pkg::OFS_EFR, 8'h1f);
		uswf_remote_inst.send(8'h13);
		uswf_remote_inst.send(8'h7e);
		chk({rsv, halt}, 8'h01);
		apb(1'b1, uswf_pkg::OFS_MCR, 8'h20);
		uswf_remote_inst.send(8'h41);
		chk({rsv, halt}, 8'h02);
		rdc(uswf_pkg::OFS_XSTAT, 8'h02);
		apb(1'b1, uswf_pkg::OFS_EFR, 8'h1b);
		uswf_remote_inst.send(8'h13);
		chk({rsv, halt}, 8'h01);
	endtask : t_rxflow
	task automatic t_special;
		apb(1'b1, uswf_pkg::OFS_STOP2, 8'h7e);
		apb(1'b1, uswf_pkg::OFS_EFR, 8'h32);
		uswf_remote_inst.send(8'h7e);
		chk(rsc, 8'h7e);
		chk({7'h0, rsv}, 8'h01);
		apb(1'b0, uswf_pkg::OFS_ISR, 8'h00);
		chk(rd & 8'h30, 8'h10);
		apb(1'b1, uswf_pkg::OFS_ISR, 8'h00);
		apb(1'b1, uswf_pkg::OFS_EFR, 8'h31);
		uswf_remote_inst.send(8'h7e);
		chk({7'h0, rsv}, 8'h00);
		apb(1'b0, uswf_pkg::OFS_ISR, 8'h00);
		chk(rd & 8'h30, 8'h30);
	endtask : t_special
	task automatic flow(input logic stop, input logic [7:0] exp, input logic [7:0] n);
		int t0;
		t0 = uswf_remote_inst.taken;
		@(posedge ref_clk);
		r_stop  <= stop;
		r_start <= !stop;
		@(posedge ref_clk);
		r_stop  <= 1'b0;
		r_start <= 1'b0;
		repeat (12) @(posedge ref_clk);
		chk(uswf_remote_inst.seen, exp);
		chk(8'(uswf_remote_inst.taken - t0), n);
	endtask : flow
	task automatic t_txflow;
		apb(1'b1, uswf_pkg::OFS_EFR, 8'h10);
		rdc(uswf_pkg::OFS_XSTAT, 8'h00);
		apb(1'b1, uswf_pkg::OFS_EFR, 8'h18);
		flow(1'b0, 8'h11, 8'h01);
		rdc(uswf_pkg::OFS_XSTAT, 8'h08);
		apb(1'b1, uswf_pkg::OFS_EFR, 8'h1c);
		flow(1'b1, 8'h7e, 8'h02);
		rdc(uswf_pkg::OFS_XSTAT, 8'h04);
		apb(1'b1, uswf_pkg::OFS_EFR, 8'h1c);
		flow(1'b1, 8'h7e, 8'h02);
		apb(1'b1, uswf_pkg::OFS_EFR, 8'h10);
		rdc(uswf_pkg::OFS_XSTAT, 8'h00);
	endtask : t_txflow
	// Direction mode with flow control off, pin copies, then a reset in mid-run
	task automatic t_pins;
		apb(1'b1, uswf_pkg::OFS_FEATURE_CTRL_REG, 8'h20);
		apb(1'b1, uswf_pkg::OFS_MCR, 8'h01);
		ir_bit  <= 1'b1;
		cfg_in  <= 3'h5;
		mode_in <= 4'ha;
		lsr_in  <= 8'h21;
		rdc(uswf_pkg::OFS_LSR, 8'h21);
		rdc(uswf_pkg::OFS_MSR, 8'ha0);
		chk({rts_n, dtr_n, iro, cc, cs, cd}, 8'h0d);
		tx_busy <= 1'b1;
		tx_load <= 1'b1;
		@(posedge ref_clk);
		tx_load <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk({7'h0, rts_n}, 8'h01);
		tx_busy <= 1'b0;
		tx_lvl  <= 8'h00;
		repeat (3) @(posedge ref_clk);
		chk({7'h0, rts_n}, 8'h00);
		rst <= 1'b1;
		@(posedge ref_clk);
		chk({so, rts_n, dtr_n, iro, cc, cs, cd}, 8'h70);
		rst <= 1'b0;
		rdc(uswf_pkg::OFS_IER, 8'h00);
		rdc(uswf_pkg::OFS_EFR, 8'h00);
		rdc(uswf_pkg::OFS_FEATURE_CTRL_REG, 8'h00);
	endtask : t_pins
	task close_out;
		$display("Comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	initial begin
		#100000;
		failures++;
		$display("MISMATCH t=%0t watchdog ran out", $time);
		close_out;
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		t_reset;
		t_gate;
		t_level;
		t_rxflow;
		t_special;
		t_txflow;
		t_pins;
		close_out;
	end
endmodule : uswf_top_tb
